// *** rtl/wfm_pkg.sv ***
// Shared constants for the wake frame error monitor
package wfm_pkg;

	// Register offsets on the 8-bit register port
	localparam logic [7:0] WFM_ADDR_ERR_COUNT = 8'h45;
	localparam logic [7:0] WFM_ADDR_ERR_LIMIT = 8'h46;
	localparam logic [7:0] WFM_ADDR_SETUP_STATUS = 8'h47;
	localparam logic [7:0] WFM_ADDR_INT_FIRST = 8'h51;

	// Wake configuration span whose writes void the setup-done bit
	localparam logic [7:0] WFM_ADDR_CFG_LO = 8'h30;
	localparam logic [7:0] WFM_ADDR_CFG_HI = 8'h44;

	// Field positions
	localparam int WFM_BIT_SETUP_DONE = 7;
	localparam int WFM_BIT_FD_LOCKED = 6;
	localparam int WFM_BIT_CLASSIC_LOCKED = 5;
	localparam int WFM_BIT_OVERFLOW = 3;

	// Values after reset
	localparam logic [7:0] WFM_RST_ERR_COUNT = 8'h00;
	localparam logic [7:0] WFM_RST_ERR_LIMIT = 8'h1F;
	localparam logic [7:0] WFM_RST_DATA = 8'h00;

	// Counter step
	localparam logic [7:0] WFM_COUNT_STEP = 8'h01;

	// Action that one received frame has on the error count
	typedef enum logic [1:0] {
		WFM_ACT_NONE = 2'b00,
		WFM_ACT_INC = 2'b01,
		WFM_ACT_DEC = 2'b10
	} wfm_act_t;

endpackage

// *** rtl/wfm_err_counter.sv ***
`timescale 1ns/1ps
// Up/down frame error counter with programmable wrap limit
module wfm_err_counter
	import wfm_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire wfm_act_t act, // Per-frame count action
	input wire logic act_valid, // One-cycle strobe with act
	input wire logic restart, // Clear count to zero
	input wire logic [7:0] limit, // Wrap limit
	output logic [7:0] count, // Current error count
	output logic overflow // One-cycle overflow pulse
);

	// Count update; restart has priority over any frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= WFM_RST_ERR_COUNT;
		end else if (restart) begin
			count <= WFM_RST_ERR_COUNT; // see (RULE5)
		end else if (act_valid) begin
			case (act)
				WFM_ACT_INC: begin
					if (count == limit) begin
						count <= WFM_RST_ERR_COUNT; // see (RULE15)
					end else begin
						count <= count + WFM_COUNT_STEP; // see (RULE1)
					end
				end
				WFM_ACT_DEC: begin
					if (count != WFM_RST_ERR_COUNT) begin
						count <= count - WFM_COUNT_STEP; // see (RULE2)
					end
				end
				default: begin
					count <= count;
				end
			endcase
		end
	end

	// Overflow pulse on the increment past the limit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			overflow <= 1'b0;
		end else begin
			overflow <= !restart && act_valid && (act == WFM_ACT_INC)
				&& (count == limit); // see (RULE4)
		end
	end

endmodule

// *** rtl/wfm_decode_status.sv ***
`timescale 1ns/1ps
// Classic and FD decode-lock flags, refreshed per frame
module wfm_decode_status (
	input wire logic clk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic detect_en, // Frame detection enabled
	input wire logic frame_end, // One-cycle end-of-frame strobe
	input wire logic frame_err, // Frame had a decode error
	input wire logic frame_fd, // Frame was an FD frame
	output logic fd_locked, // FD frames decoded correctly
	output logic classic_locked // Classic frames decoded correctly
);

	// Hardware-maintained flags, dropped when detection is off
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fd_locked <= 1'b0;
			classic_locked <= 1'b0;
		end else if (!detect_en) begin
			fd_locked <= 1'b0; // see (RULE12)
			classic_locked <= 1'b0; // see (RULE12)
		end else if (frame_end) begin
			// FD error flag covers the frame up to the data field
			fd_locked <= frame_fd && !frame_err; // see (RULE9) (RULE11)
			classic_locked <= !frame_fd && !frame_err; // see (RULE10) (RULE11)
		end
	end

endmodule

// *** rtl/wfm_monitor.sv ***
`timescale 1ns/1ps
// How it works
// (RULE1) Each frame with stuff, CRC or CRC delimiter error adds one to count.
// (RULE2) Each good frame subtracts one from count, never going below zero.
// (RULE3) With FD frames ignored, FD frames leave the count unchanged.
// (RULE4) An increment while count equals the limit is an overflow.
// (RULE5) Enabling frame detection or idle-time detection clears the count.
// (RULE6) The error limit resets to 31, so the 32nd error overflows.
// (RULE7) Host sets setup-done last, after all wake settings are written.
// (RULE8) Writes to 0x30..0x44 or 0x46 clear the setup-done bit.
// (RULE9) FD-decode flag shows FD frames decode correctly up to data field.
// (RULE10) Classic-decode flag shows classic frames decode correctly.
// (RULE11) Both decode flags are refreshed after every received frame.
// (RULE12) Decode flags are read-only and cleared by hardware alone.
// (RULE13) FD ignore at zero counts FD frames as errors; at one ignores them.
// (RULE14) Overflow shows as write-one-to-clear bit three of first int register.
// (RULE15) On overflow the count restarts at zero; flag holds until cleared.
module wfm_monitor
	import wfm_pkg::*;
(
	input wire logic clk, // System clock, 25 MHz
	input wire logic rst_n, // Async reset, active low
	// Register port from the serial interface decoder
	input wire logic [7:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // One-cycle write strobe
	input wire logic reg_rd, // One-cycle read strobe
	output logic [7:0] reg_rdata, // Read data, registered
	output logic reg_rvalid, // Read data valid pulse
	// Frame decoder, same clock
	input wire logic frame_end, // One-cycle end-of-frame strobe
	input wire logic frame_err, // Stuff, CRC or delimiter error
	input wire logic frame_fd, // Frame recognised as FD
	// Settings held in other register blocks
	input wire logic frame_detect_en, // Frame detection enable
	input wire logic idle_detect_en, // Bus idle-time detection enable
	input wire logic fd_frames_ignored, // FD frames ignored when high
	// Status toward the rest of the device
	output logic frame_count_overflow_flag, // Sticky overflow flag
	output logic wake_setup_done, // Wake configuration complete
	output logic fd_decode_locked, // FD decode status
	output logic classic_decode_locked // Classic decode status
);

	logic [7:0] frame_error_count;
	logic [7:0] frame_error_limit;
	logic count_overflow;
	logic fd_locked;
	logic classic_locked;
	logic detect_en_q;
	logic idle_en_q;
	logic count_restart;
	logic next_act_valid;
	wfm_act_t next_act;
	logic wr_limit;
	logic wr_setup;
	logic wr_int_first;
	logic wr_cfg_span;
	logic [7:0] next_rdata;

	// Write decode
	assign wr_limit = reg_wr && (reg_addr == WFM_ADDR_ERR_LIMIT);
	assign wr_setup = reg_wr && (reg_addr == WFM_ADDR_SETUP_STATUS);
	assign wr_int_first = reg_wr && (reg_addr == WFM_ADDR_INT_FIRST);
	assign wr_cfg_span = reg_wr && (((reg_addr >= WFM_ADDR_CFG_LO)
		&& (reg_addr <= WFM_ADDR_CFG_HI))
		|| (reg_addr == WFM_ADDR_ERR_LIMIT)); // see (RULE8)

	// Enable history for rising-edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			detect_en_q <= 1'b0;
			idle_en_q <= 1'b0;
		end else begin
			detect_en_q <= frame_detect_en;
			idle_en_q <= idle_detect_en;
		end
	end

	// Count restarts on the act of enabling either detector
	assign count_restart = (frame_detect_en && !detect_en_q)
		|| (idle_detect_en && !idle_en_q); // see (RULE5)

	// Map a finished frame onto a count action
	always_comb begin
		next_act = WFM_ACT_NONE;
		next_act_valid = frame_end;
		if (frame_fd) begin
			if (fd_frames_ignored) begin
				next_act = WFM_ACT_NONE; // see (RULE3) (RULE13)
			end else begin
				next_act = WFM_ACT_INC; // see (RULE13)
			end
		end else if (frame_err) begin
			next_act = WFM_ACT_INC; // see (RULE1)
		end else begin
			next_act = WFM_ACT_DEC; // see (RULE2)
		end
	end

	// Error counter
	wfm_err_counter u_counter (
		.clk(clk),
		.rst_n(rst_n),
		.act(next_act),
		.act_valid(next_act_valid),
		.restart(count_restart),
		.limit(frame_error_limit),
		.count(frame_error_count),
		.overflow(count_overflow)
	);

	// Decode-lock flags
	wfm_decode_status u_status (
		.clk(clk),
		.rst_n(rst_n),
		.detect_en(frame_detect_en),
		.frame_end(frame_end),
		.frame_err(frame_err),
		.frame_fd(frame_fd),
		.fd_locked(fd_locked),
		.classic_locked(classic_locked)
	);

	// Status outputs straight from flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fd_decode_locked <= 1'b0;
			classic_decode_locked <= 1'b0;
		end else begin
			fd_decode_locked <= fd_locked;
			classic_decode_locked <= classic_locked;
		end
	end

	// Error limit register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_error_limit <= WFM_RST_ERR_LIMIT; // see (RULE6)
		end else if (wr_limit) begin
			frame_error_limit <= reg_wdata;
		end
	end

	// Setup-done bit: host sets it, config writes void it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_setup_done <= 1'b0;
		end else if (wr_setup) begin
			wake_setup_done <= reg_wdata[WFM_BIT_SETUP_DONE];
		end else if (wr_cfg_span) begin
			wake_setup_done <= 1'b0; // see (RULE8)
		end
	end

	// Sticky overflow flag, write one to clear; set wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_count_overflow_flag <= 1'b0;
		end else if (count_overflow) begin
			frame_count_overflow_flag <= 1'b1; // see (RULE4) (RULE15)
		end else if (wr_int_first && reg_wdata[WFM_BIT_OVERFLOW]) begin
			frame_count_overflow_flag <= 1'b0; // see (RULE14)
		end
	end

	// Read mux; unmapped addresses read as zero
	always_comb begin
		next_rdata = WFM_RST_DATA;
		case (reg_addr)
			WFM_ADDR_ERR_COUNT: begin
				next_rdata = frame_error_count;
			end
			WFM_ADDR_ERR_LIMIT: begin
				next_rdata = frame_error_limit;
			end
			WFM_ADDR_SETUP_STATUS: begin
				next_rdata[WFM_BIT_SETUP_DONE] = wake_setup_done;
				next_rdata[WFM_BIT_FD_LOCKED] = fd_locked; // see (RULE12)
				next_rdata[WFM_BIT_CLASSIC_LOCKED] = classic_locked;
			end
			WFM_ADDR_INT_FIRST: begin
				next_rdata[WFM_BIT_OVERFLOW] =
					frame_count_overflow_flag; // see (RULE14)
			end
			default: begin
				next_rdata = WFM_RST_DATA;
			end
		endcase
	end

	// Registered read answer, one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= WFM_RST_DATA;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end

endmodule

// *** dv/wfm_monitor_properties.sv ***
`timescale 1ns/1ps
// Port-level checks of the frame error monitor
module wfm_checker
	import wfm_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic [7:0] reg_addr, // Address
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic reg_rvalid, // Read valid
	input wire logic frame_end, // Frame strobe
	input wire logic frame_err, // Frame error
	input wire logic frame_fd, // FD frame
	input wire logic frame_detect_en, // Detect enable
	input wire logic frame_count_overflow_flag, // Overflow flag
	input wire logic wake_setup_done, // Setup done
	input wire logic fd_decode_locked, // FD lock
	input wire logic classic_decode_locked // Classic lock
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Good frame seen with detection on, and overflow clear write
	wire good = frame_end && frame_detect_en && !frame_err;
	wire w1c = reg_wr && reg_addr == WFM_ADDR_INT_FIRST && reg_wdata[3];
	rd_answer_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read got no answer");
	cfg_clear_a: assert property (reg_wr && (reg_addr inside
		{[8'h30:8'h44], 8'h46}) |=> !wake_setup_done)
		else $error("setup done not cleared");
	lock_excl_a: assert property (
		!(fd_decode_locked && classic_decode_locked))
		else $error("both decode flags set");
	fd_lock_a: assert property (good && frame_fd |-> ##2 fd_decode_locked)
		else $error("fd lock missing");
	cl_lock_a: assert property (
		good && !frame_fd |-> ##2 classic_decode_locked)
		else $error("classic lock missing");
	err_unlock_a: assert property (frame_end && frame_err |->
		##2 !fd_decode_locked && !classic_decode_locked)
		else $error("lock kept after bad frame");
	off_clear_a: assert property (!frame_detect_en |->
		##2 !fd_decode_locked && !classic_decode_locked)
		else $error("lock kept with detection off");
	ovf_hold_a: assert property (frame_count_overflow_flag && !w1c
		&& !$past(w1c) |=> frame_count_overflow_flag)
		else $error("overflow flag lost");
	ovf_clear_a: assert property (w1c && !frame_end &&
		!$past(frame_end) ##1 !frame_end |-> ##1 !frame_count_overflow_flag)
		else $error("overflow flag not cleared");
endmodule
bind wfm_monitor wfm_checker u_chk(.*);

// *** dv/wfm_can_node.sv ***
`timescale 1ns/1ps
// Bus node model issuing decoded frame events
module wfm_can_node (
	input wire logic clk, // Clock
	output logic frame_end, // Frame strobe
	output logic frame_err, // Error qualifier
	output logic frame_fd // FD qualifier
);
	initial begin
		frame_end = 1'b0;
		frame_err = 1'b0;
		frame_fd = 1'b0;
	end
	// One frame, then a spare cycle with both qualifiers inverted
	task send(input logic err, input logic fd);
		frame_end = 1'b1;
		frame_err = err;
		frame_fd = fd;
		@(posedge clk);
		#1;
		frame_end = 1'b0;
		frame_err = ~err;
		frame_fd = ~fd;
		@(posedge clk);
		#1;
	endtask
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps
// Register and frame tests of the monitor
module testbench;
	import wfm_pkg::*;
	localparam logic [7:0] CNT = WFM_ADDR_ERR_COUNT;
	localparam logic [7:0] STS = WFM_ADDR_SETUP_STATUS;
	localparam logic [7:0] INT = WFM_ADDR_INT_FIRST;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid;
	logic frame_end, frame_err, frame_fd;
	logic frame_detect_en = 1'b0, idle_detect_en = 1'b0;
	logic fd_frames_ignored = 1'b1;
	logic frame_count_overflow_flag, wake_setup_done;
	logic fd_decode_locked, classic_decode_locked;
	logic [7:0] adr [5] = '{8'h2F, 8'h30, 8'h44, 8'h45, 8'h46};
	logic [7:0] exs [5] = '{8'h80, 8'h00, 8'h00, 8'h80, 8'h00};
	int num_errors = 0;
	int checked = 0;
	always #20 clk = ~clk;
	wfm_can_node node(.*);
	wfm_monitor dut(.*);
	task final_report;
		if (num_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task check(input string n, input logic [7:0] got, input logic [7:0] e);
		checked++;
		if (got !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, got);
		end
	endtask
	task tick;
		@(posedge clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		tick;
		reg_wr = 1'b0;
		tick;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1'b1;
		tick;
		reg_rd = 1'b0;
		tick;
		check($sformatf("reg %h", a), reg_rdata, e);
	endtask
	// Cut a hung run short
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		final_report;
	end
	initial begin
		repeat (12) @(posedge clk);
		#1 rst_n = 1'b1;
		rd(CNT, 8'h00);
		rd(WFM_ADDR_ERR_LIMIT, 8'h1F);
		rd(STS, 8'h00);
		rd(8'h48, 8'h00);
		wr(CNT, 8'h55);
		rd(CNT, 8'h00);
		frame_detect_en = 1'b1;
		tick;
		repeat (31) node.send(1'b1, 1'b0);
		rd(CNT, 8'h1F);
		check("ovf", {7'h00, frame_count_overflow_flag}, 8'h00);
		node.send(1'b1, 1'b0);
		rd(CNT, 8'h00);
		rd(INT, 8'h08);
		node.send(1'b0, 1'b0);
		rd(CNT, 8'h00);
		wr(INT, 8'hF7);
		rd(INT, 8'h08);
		wr(INT, 8'h08);
		rd(INT, 8'h00);
		wr(WFM_ADDR_ERR_LIMIT, 8'h03);
		repeat (3) node.send(1'b1, 1'b0);
		node.send(1'b0, 1'b0);
		rd(CNT, 8'h02);
		node.send(1'b0, 1'b1);
		rd(CNT, 8'h02);
		rd(STS, 8'h40);
		fd_frames_ignored = 1'b0;
		node.send(1'b0, 1'b1);
		rd(CNT, 8'h03);
		node.send(1'b1, 1'b0);
		rd(CNT, 8'h00);
		rd(STS, 8'h00);
		check("ovf", {7'h00, frame_count_overflow_flag}, 8'h01);
		node.send(1'b0, 1'b0);
		rd(STS, 8'h20);
		frame_detect_en = 1'b0;
		tick;
		rd(STS, 8'h00);
		node.send(1'b1, 1'b0);
		node.send(1'b1, 1'b0);
		frame_detect_en = 1'b1;
		tick;
		rd(CNT, 8'h00);
		node.send(1'b1, 1'b0);
		idle_detect_en = 1'b1;
		tick;
		rd(CNT, 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(STS, 8'h80);
			wr(adr[i], 8'h00);
			rd(STS, exs[i]);
		end
		final_report;
	end
endmodule
